// ### hcreg_top.sv
`timescale 1ns/1ps
module hcreg_top
  import hcreg_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [DATA_W-1:0] reg_rdata,
  input wire logic data_bus_32,
  output logic host_regs_reset,
  output logic all_regs_reset,
  output logic dma_active,
  output logic dma_burst_req,
  input wire logic dma_burst_ack,
  output logic [4:0] dma_burst_beats,
  output logic [23:0] dma_bursts_left,
  output logic dma_to_ram,
  output logic dma_done,
  output logic [1:0] walk_area,
  output logic [HDR_IDX_W-1:0] walk_index,
  output logic walk_lookup,
  input wire logic hdr_valid,
  input wire logic hdr_skip,
  output logic transfer_descriptor_req,
  input wire logic transfer_descriptor_done
);

  // Rounded-up right shift: ceiling of v divided by 2**sh
  function automatic logic [23:0] ceil_shr(input logic [23:0] v,
                                           input logic [2:0] sh);
    logic [23:0] mask;
    mask = ~(24'hff_ffff << sh);
    ceil_shr = (v >> sh) + {23'h00_0000, |(v & mask)};
  endfunction

  // Burst code to log2 of the beats in one burst
  function automatic logic [2:0] burst_shift(input logic [1:0] code);
    case (code)
      BURST_SINGLE: burst_shift = 3'h0;
      BURST_4: burst_shift = 3'h2;
      BURST_8: burst_shift = 3'h3;
      BURST_16: burst_shift = 3'h4;
      default: burst_shift = 3'h0;
    endcase
  endfunction

  // Burst code to the beat count shown to the DMA side
  function automatic logic [4:0] burst_beats(input logic [1:0] code);
    case (code)
      BURST_SINGLE: burst_beats = BEATS_SINGLE;
      BURST_4: burst_beats = BEATS_4;
      BURST_8: burst_beats = BEATS_8;
      BURST_16: burst_beats = BEATS_16;
      default: burst_beats = BEATS_SINGLE;
    endcase
  endfunction

  logic [31:0] test_word_reg;
  logic [1:0] soft_reset_reg;
  logic [23:0] dma_count_reg;
  logic [1:0] dma_burst_reg;
  logic dma_run_reg;
  logic dma_dir_reg;
  logic [2:0] fill_flags_reg;
  hcreg_dma_state_t dma_state_reg;
  hcreg_walk_state_t walk_state_reg;
  logic [23:0] words_next;
  logic [23:0] bursts_next;
  logic sw_all;
  logic sw_host;
  logic wr_test;
  logic wr_soft;
  logic wr_dma;
  logic wr_fill;
  logic dma_start;
  logic dma_stop;
  logic hdr_take;
  logic [1:0] area_next;
  logic area_found;

  assign sw_all = soft_reset_reg[RST_ALL_BIT];
  assign sw_host = soft_reset_reg[RST_HOST_BIT];
  // Write decodes need an exact address match
  assign wr_test = reg_wr && (reg_addr == TEST_WORD_OFS);
  assign wr_soft = reg_wr && (reg_addr == SOFT_RESET_OFS);
  assign wr_dma = reg_wr && (reg_addr == DMA_SETUP_OFS);
  assign wr_fill = reg_wr && (reg_addr == FILL_FLAGS_OFS);

  // Soft reset bits are never cleared by the reset they drive, so a
  // reset stays asserted until software writes zero
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      soft_reset_reg <= SOFT_RESET_RST;
    end else if (wr_soft) begin
      soft_reset_reg <= reg_wdata[1:0];
    end
  end

  // Reset outputs follow the bits one cycle after the write; the full bit also drives the host reset
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      host_regs_reset <= 1'b0;
      all_regs_reset <= 1'b0;
    end else begin
      host_regs_reset <= sw_host || sw_all;
      all_regs_reset <= sw_all;
    end
  end

  // Test word is plain storage; only the full reset clears it
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      test_word_reg <= TEST_WORD_RST;
    end else if (sw_all) begin
      test_word_reg <= TEST_WORD_RST;
    end else if (wr_test) begin
      test_word_reg <= reg_wdata;
    end
  end

  // DMA setup fields; the full reset also drops the run bit
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      dma_count_reg <= DMA_COUNT_RST;
      dma_burst_reg <= DMA_BURST_RST;
      dma_run_reg <= 1'b0;
      dma_dir_reg <= 1'b0;
    end else if (sw_all) begin
      dma_count_reg <= DMA_COUNT_RST;
      dma_burst_reg <= DMA_BURST_RST;
      dma_run_reg <= 1'b0;
      dma_dir_reg <= 1'b0;
    end else if (wr_dma) begin
      dma_count_reg <= reg_wdata[DMA_COUNT_HI:DMA_COUNT_LO];
      dma_burst_reg <= reg_wdata[DMA_BURST_HI:DMA_BURST_LO];
      dma_run_reg <= reg_wdata[DMA_RUN_BIT];
      dma_dir_reg <= reg_wdata[DMA_DIR_BIT];
    end
  end

  // Fill flags sit above the host-only range, so only the full reset
  // clears them; the host reset stops the walker but keeps the flags
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      fill_flags_reg <= FILL_FLAGS_RST;
    end else if (sw_all) begin
      fill_flags_reg <= FILL_FLAGS_RST;
    end else if (wr_fill) begin
      fill_flags_reg <= reg_wdata[FILL_ISO_BIT:FILL_ASYNC_BIT];
    end
  end

  // Reserved bits are not stored and read back as zero
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      reg_rdata <= 32'h0000_0000;
    end else if (reg_rd) begin
      case (reg_addr)
        TEST_WORD_OFS: reg_rdata <= test_word_reg;
        SOFT_RESET_OFS: reg_rdata <= {30'h0000_0000, soft_reset_reg};
        DMA_SETUP_OFS: reg_rdata <= {dma_count_reg, 4'h0, dma_burst_reg,
                                     dma_run_reg, dma_dir_reg};
        FILL_FLAGS_OFS: reg_rdata <= {29'h0000_0000, fill_flags_reg};
        default: reg_rdata <= 32'h0000_0000;
      endcase
    end else begin
      reg_rdata <= 32'h0000_0000;
    end
  end

  // Byte count becomes bus words, then whole bursts, rounding up
  always_comb begin
    words_next = ceil_shr(reg_wdata[DMA_COUNT_HI:DMA_COUNT_LO],
                          data_bus_32 ? SHIFT_32BIT : SHIFT_16BIT);
    bursts_next = ceil_shr(words_next,
                           burst_shift(reg_wdata[DMA_BURST_HI:
                                                 DMA_BURST_LO]));
  end

  // A run-bit edge from zero to one in a write starts a transfer
  assign dma_start = wr_dma && reg_wdata[DMA_RUN_BIT] && !dma_run_reg
                     && !sw_all;
  assign dma_stop = sw_all || (wr_dma && !reg_wdata[DMA_RUN_BIT]);

  // One request per burst, held until the far side takes it; the bus
  // width is sampled once, when the transfer starts
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      dma_state_reg <= HCREG_DMA_IDLE;
      dma_bursts_left <= 24'h00_0000;
      dma_burst_req <= 1'b0;
      dma_active <= 1'b0;
      dma_done <= 1'b0;
    end else begin
      dma_done <= 1'b0;
      if (dma_stop) begin
        dma_state_reg <= HCREG_DMA_IDLE;
        dma_bursts_left <= 24'h00_0000;
        dma_burst_req <= 1'b0;
        dma_active <= 1'b0;
      end else begin
        case (dma_state_reg)
          HCREG_DMA_IDLE: begin
            if (dma_start && bursts_next != 24'h00_0000) begin
              dma_state_reg <= HCREG_DMA_BURST;
              dma_bursts_left <= bursts_next;
              dma_burst_req <= 1'b1;
              dma_active <= 1'b1;
            end else if (dma_start) begin
              dma_done <= 1'b1;
            end
          end
          HCREG_DMA_BURST: begin
            if (dma_burst_ack) begin
              dma_bursts_left <= dma_bursts_left - 24'h00_0001;
              dma_burst_req <= 1'b0;
              dma_state_reg <= HCREG_DMA_WAIT;
            end
          end
          HCREG_DMA_WAIT: begin
            if (dma_bursts_left == 24'h00_0000) begin
              dma_state_reg <= HCREG_DMA_IDLE;
              dma_active <= 1'b0;
              dma_done <= 1'b1;
            end else begin
              dma_state_reg <= HCREG_DMA_BURST;
              dma_burst_req <= 1'b1;
            end
          end
          default: begin
            dma_state_reg <= HCREG_DMA_IDLE;
            dma_burst_req <= 1'b0;
            dma_active <= 1'b0;
          end
        endcase
      end
    end
  end

  // Burst size and direction follow the stored setup one cycle later
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      dma_burst_beats <= BEATS_SINGLE;
      dma_to_ram <= 1'b1;
    end else begin
      dma_burst_beats <= burst_beats(dma_burst_reg);
      dma_to_ram <= !dma_dir_reg;
    end
  end

  // Next filled area strictly after the current one; empty ones skipped
  always_comb begin
    area_found = 1'b0;
    area_next = AREA_ASYNC;
    for (int i = AREA_COUNT - 1; i >= 0; i--) begin
      if (fill_flags_reg[i] && (2'(i) > walk_area)) begin
        area_found = 1'b1;
        area_next = 2'(i);
      end
    end
  end

  // A header is taken only if valid and not marked to be skipped
  assign hdr_take = hdr_valid && !hdr_skip;

  // One header index is examined per cycle while lookup is high; a
  // flag cleared during a scan ends that area at once; one cleared while a descriptor is processed ends it after done
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      walk_state_reg <= HCREG_WALK_IDLE;
      walk_area <= AREA_ASYNC;
      walk_index <= 5'h00;
      walk_lookup <= 1'b0;
      transfer_descriptor_req <= 1'b0;
    end else if (sw_all || sw_host) begin
      walk_state_reg <= HCREG_WALK_IDLE;
      walk_area <= AREA_ASYNC;
      walk_index <= 5'h00;
      walk_lookup <= 1'b0;
      transfer_descriptor_req <= 1'b0;
    end else begin
      case (walk_state_reg)
        HCREG_WALK_IDLE: begin
          walk_index <= 5'h00;
          if (fill_flags_reg[FILL_ASYNC_BIT]) begin
            walk_area <= AREA_ASYNC;
            walk_lookup <= 1'b1;
            walk_state_reg <= HCREG_WALK_SCAN;
          end else if (fill_flags_reg[FILL_INT_BIT]) begin
            walk_area <= 2'h1;
            walk_lookup <= 1'b1;
            walk_state_reg <= HCREG_WALK_SCAN;
          end else if (fill_flags_reg[FILL_ISO_BIT]) begin
            walk_area <= AREA_ISO;
            walk_lookup <= 1'b1;
            walk_state_reg <= HCREG_WALK_SCAN;
          end
        end
        HCREG_WALK_SCAN: begin
          if (!fill_flags_reg[walk_area]) begin
            walk_lookup <= 1'b0;
            walk_state_reg <= HCREG_WALK_IDLE;
          end else if (hdr_take) begin
            walk_lookup <= 1'b0;
            transfer_descriptor_req <= 1'b1;
            walk_state_reg <= HCREG_WALK_PROC;
          end else if (walk_index != HDR_LAST) begin
            walk_index <= walk_index + 5'h01;
          end else if (area_found) begin
            walk_area <= area_next;
            walk_index <= 5'h00;
          end else begin
            walk_lookup <= 1'b0;
            walk_state_reg <= HCREG_WALK_IDLE;
          end
        end
        HCREG_WALK_PROC: begin
          if (transfer_descriptor_done) begin
            transfer_descriptor_req <= 1'b0;
            if (walk_index != HDR_LAST) begin
              walk_index <= walk_index + 5'h01;
              walk_lookup <= 1'b1;
              walk_state_reg <= HCREG_WALK_SCAN;
            end else if (area_found) begin
              walk_area <= area_next;
              walk_index <= 5'h00;
              walk_lookup <= 1'b1;
              walk_state_reg <= HCREG_WALK_SCAN;
            end else begin
              walk_state_reg <= HCREG_WALK_IDLE;
            end
          end
        end
        default: begin
          walk_state_reg <= HCREG_WALK_IDLE;
          walk_lookup <= 1'b0;
          transfer_descriptor_req <= 1'b0;
        end
      endcase
    end
  end

endmodule

// ### hcreg_pkg.sv
// Function
// - Test word reads back last written value
// - Host reset bit clears host registers only
// - Full reset clears all but the reset bits; zero does nothing
// - Upper 24 bits hold DMA byte count
// - Burst count depends on byte count, width
// - Burst field picks 1, 4, 8, 16 beats
// - Direction zero writes RAM, one reads
// - Fill flag means area holds descriptors
// - Walk headers, process valid unskipped ones
// - Flag bits 2,1,0; clear flag skips area
package hcreg_pkg;
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;
  localparam logic [11:0] TEST_WORD_OFS = 12'h308;
  localparam logic [11:0] SOFT_RESET_OFS = 12'h30c;
  localparam logic [11:0] DMA_SETUP_OFS = 12'h330;
  localparam logic [11:0] FILL_FLAGS_OFS = 12'h334;
  localparam logic [31:0] TEST_WORD_RST = 32'h0000_0000;
  localparam logic [1:0] SOFT_RESET_RST = 2'h0;
  localparam logic [23:0] DMA_COUNT_RST = 24'h00_0000;
  localparam logic [1:0] DMA_BURST_RST = 2'h0;
  localparam logic [2:0] FILL_FLAGS_RST = 3'h0;
  localparam int RST_ALL_BIT = 0;
  localparam int RST_HOST_BIT = 1;
  localparam int DMA_DIR_BIT = 0;
  localparam int DMA_RUN_BIT = 1;
  localparam int DMA_BURST_LO = 2;
  localparam int DMA_BURST_HI = 3;
  localparam int DMA_COUNT_LO = 8;
  localparam int DMA_COUNT_HI = 31;
  localparam int FILL_ASYNC_BIT = 0;
  localparam int FILL_INT_BIT = 1;
  localparam int FILL_ISO_BIT = 2;
  localparam logic [1:0] BURST_SINGLE = 2'h0;
  localparam logic [1:0] BURST_4 = 2'h1;
  localparam logic [1:0] BURST_8 = 2'h2;
  localparam logic [1:0] BURST_16 = 2'h3;
  localparam logic [4:0] BEATS_SINGLE = 5'h01;
  localparam logic [4:0] BEATS_4 = 5'h04;
  localparam logic [4:0] BEATS_8 = 5'h08;
  localparam logic [4:0] BEATS_16 = 5'h10;
  localparam logic [2:0] SHIFT_16BIT = 3'h1;
  localparam logic [2:0] SHIFT_32BIT = 3'h2;
  localparam int AREA_COUNT = 3;
  localparam int HDR_IDX_W = 5;
  localparam logic [4:0] HDR_LAST = 5'h1f;
  localparam logic [1:0] AREA_ASYNC = 2'h0;
  localparam logic [1:0] AREA_ISO = 2'h2;
  typedef enum logic [1:0] {
    HCREG_DMA_IDLE = 2'b00,
    HCREG_DMA_BURST = 2'b01,
    HCREG_DMA_WAIT = 2'b10
  } hcreg_dma_state_t;
  typedef enum logic [1:0] {
    HCREG_WALK_IDLE = 2'b00,
    HCREG_WALK_SCAN = 2'b01,
    HCREG_WALK_PROC = 2'b10
  } hcreg_walk_state_t;
endpackage

// ### hcreg_checker.sv
`timescale 1ns/1ps
module hcreg_checker
  import hcreg_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [DATA_W-1:0] reg_rdata,
  input wire logic host_regs_reset,
  input wire logic all_regs_reset,
  input wire logic dma_active,
  input wire logic dma_burst_req,
  input wire logic dma_burst_ack,
  input wire logic [4:0] dma_burst_beats,
  input wire logic dma_done,
  input wire logic walk_lookup,
  input wire logic hdr_valid,
  input wire logic hdr_skip,
  input wire logic transfer_descriptor_req,
  input wire logic transfer_descriptor_done
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_b);
  wire logic sr_wr = reg_wr && reg_addr == SOFT_RESET_OFS;
  wire logic dm_wr = reg_wr && reg_addr == DMA_SETUP_OFS;
  rd_idle_zero_a: assert property (
    !$past(reg_rd) |-> reg_rdata == '0) else $error("stray read data");
  rd_unmapped_a: assert property (
    reg_rd && reg_addr == 12'h300 |=> reg_rdata == '0)
    else $error("unmapped read not zero");
  full_set_a: assert property (
    sr_wr && reg_wdata[RST_ALL_BIT]
    |-> ##2 all_regs_reset && host_regs_reset)
    else $error("full reset not applied");
  host_set_a: assert property (
    sr_wr && reg_wdata[RST_HOST_BIT] |-> ##2 host_regs_reset)
    else $error("host reset not applied");
  reset_release_a: assert property (
    sr_wr && reg_wdata[1:0] == 2'h0
    |-> ##2 !host_regs_reset && !all_regs_reset)
    else $error("reset not released");
  burst_hold_a: assert property (
    dma_burst_req && !dma_burst_ack && !reg_wr && !$past(reg_wr) &&
    !all_regs_reset |=> dma_burst_req) else $error("burst request dropped");
  dma_abort_a: assert property (
    dm_wr && !reg_wdata[DMA_RUN_BIT] && dma_active |=> !dma_active && !dma_done)
    else $error("abort not immediate");
  done_pulse_a: assert property (
    dma_done |=> !dma_done) else $error("done longer than a cycle");
  beats_code_a: assert property (
    dma_burst_req |-> dma_burst_beats inside {5'h01, 5'h04, 5'h08, 5'h10})
    else $error("bad beat count");
  full_stop_a: assert property (
    all_regs_reset |=> !dma_active && !transfer_descriptor_req)
    else $error("engines run under full reset");
  hdr_take_a: assert property (
    walk_lookup && hdr_valid && !hdr_skip && !host_regs_reset && !reg_wr &&
    !$past(reg_wr) |=> transfer_descriptor_req)
    else $error("valid header not processed");
  hdr_pass_a: assert property (
    walk_lookup && (!hdr_valid || hdr_skip) |=> !transfer_descriptor_req)
    else $error("bad header processed");
  td_hold_a: assert property (
    transfer_descriptor_req && !transfer_descriptor_done && !reg_wr &&
    !$past(reg_wr) && !host_regs_reset |=> transfer_descriptor_req)
    else $error("descriptor request dropped");
  dma_done_c: cover property (dma_done);
  td_req_c: cover property (transfer_descriptor_req);
  full_rst_c: cover property (all_regs_reset);
endmodule
bind hcreg_top hcreg_checker i_chk (.ref_clk, .rst_b, .reg_addr, .reg_wdata,
  .reg_wr, .reg_rd, .reg_rdata, .host_regs_reset, .all_regs_reset,
  .dma_active, .dma_burst_req, .dma_burst_ack, .dma_burst_beats, .dma_done,
  .walk_lookup, .hdr_valid, .hdr_skip, .transfer_descriptor_req,
  .transfer_descriptor_done);

// ### hcreg_partner.sv
`timescale 1ns/1ps
module hcreg_partner (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic dma_burst_req,
  output logic dma_burst_ack,
  input wire logic walk_lookup,
  input wire logic [4:0] walk_index,
  output logic hdr_valid,
  output logic hdr_skip,
  input wire logic transfer_descriptor_req,
  output logic transfer_descriptor_done
);
  logic [1:0] wait_reg;
  logic tog_reg;
  // Slow ack: a burst is taken in the fourth cycle of its request
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      wait_reg <= 2'h0;
      dma_burst_ack <= 1'b0;
      transfer_descriptor_done <= 1'b0;
      tog_reg <= 1'b0;
    end else begin
      wait_reg <= (dma_burst_req && !dma_burst_ack) ? wait_reg + 2'h1 : 2'h0;
      dma_burst_ack <= dma_burst_req && !dma_burst_ack && wait_reg == 2'h2;
      transfer_descriptor_done <= transfer_descriptor_req &&
        !transfer_descriptor_done;
      tog_reg <= !tog_reg;
    end
  end
  // Even headers valid, header 2 skipped; lines scramble outside lookups
  assign hdr_valid = walk_lookup ? !walk_index[0] : tog_reg;
  assign hdr_skip = walk_lookup ? walk_index == 5'h2 : !tog_reg;
endmodule

// ### tb.sv
`timescale 1ns/1ps
module tb
  import hcreg_pkg::*;
;
  logic ref_clk, rst_b, reg_wr, reg_rd, data_bus_32;
  logic [11:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata;
  logic host_regs_reset, all_regs_reset, dma_active, dma_burst_req;
  logic dma_burst_ack, dma_to_ram, dma_done, walk_lookup, hdr_valid;
  logic hdr_skip, transfer_descriptor_req, transfer_descriptor_done;
  logic [4:0] dma_burst_beats, walk_index;
  logic [23:0] dma_bursts_left;
  logic [1:0] walk_area;
  logic [3:0] area_seen;
  int error_cnt, num_checks, cyc, acks, dones, bad, procs;
  hcreg_top i_hcreg_top (.ref_clk, .rst_b, .reg_addr, .reg_wdata, .reg_wr,
    .reg_rd, .reg_rdata, .data_bus_32, .host_regs_reset, .all_regs_reset,
    .dma_active, .dma_burst_req, .dma_burst_ack, .dma_burst_beats,
    .dma_bursts_left, .dma_to_ram, .dma_done, .walk_area, .walk_index,
    .walk_lookup, .hdr_valid, .hdr_skip, .transfer_descriptor_req,
    .transfer_descriptor_done);
  hcreg_partner i_hcreg_partner (.ref_clk, .rst_b, .dma_burst_req,
    .dma_burst_ack, .walk_lookup, .walk_index, .hdr_valid, .hdr_skip,
    .transfer_descriptor_req, .transfer_descriptor_done);
  always #5 ref_clk = !ref_clk;
  always @(posedge ref_clk) begin
    cyc++;
    if (dma_burst_req && dma_burst_ack) acks++;
    if (dma_done) dones++;
    if (transfer_descriptor_req) begin
      procs++;
      area_seen[walk_area] = 1'b1;
      if (walk_area == 2'h1 || walk_index[0] || walk_index == 5'h2) bad++;
    end
    if (cyc == 20000) begin
      error_cnt++;
      tally_and_finish();
    end
  end
  task tally_and_finish;
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask
  task rd(input logic [11:0] a, input logic [31:0] exp);
    @(posedge ref_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1;
    chk(reg_rdata, exp);
  endtask
  task settle;
    @(posedge ref_clk);
    #1;
  endtask
  task t_regs;
    rd(TEST_WORD_OFS, 32'h0);
    rd(SOFT_RESET_OFS, 32'h0);
    rd(DMA_SETUP_OFS, 32'h0);
    rd(FILL_FLAGS_OFS, 32'h0);
    wr(12'h304, 32'h1);
    rd(12'h300, 32'h0);
    wr(TEST_WORD_OFS, 32'ha5c3_0f96);
    rd(TEST_WORD_OFS, 32'ha5c3_0f96);
    wr(TEST_WORD_OFS, 32'h5a3c_f069);
    rd(TEST_WORD_OFS, 32'h5a3c_f069);
    wr(DMA_SETUP_OFS, 32'h1234_560d);
    rd(DMA_SETUP_OFS, 32'h1234_560d);
  endtask
  task t_sreset;
    wr(FILL_FLAGS_OFS, 32'h5);
    wr(SOFT_RESET_OFS, 32'h2);
    settle();
    chk(host_regs_reset, 1'b1);
    chk(all_regs_reset, 1'b0);
    rd(FILL_FLAGS_OFS, 32'h5);
    rd(TEST_WORD_OFS, 32'h5a3c_f069);
    rd(SOFT_RESET_OFS, 32'h2);
    wr(FILL_FLAGS_OFS, 32'h1);
    rd(FILL_FLAGS_OFS, 32'h1);
    wr(SOFT_RESET_OFS, 32'h0);
    settle();
    chk(host_regs_reset, 1'b0);
    wr(SOFT_RESET_OFS, 32'h1);
    settle();
    chk(all_regs_reset, 1'b1);
    wr(TEST_WORD_OFS, 32'hffff_ffff);
    rd(TEST_WORD_OFS, 32'h0);
    rd(DMA_SETUP_OFS, 32'h0);
    rd(FILL_FLAGS_OFS, 32'h0);
    wr(SOFT_RESET_OFS, 32'h0);
    settle();
    chk(all_regs_reset, 1'b0);
  endtask
  task t_dma;
    int w, c, n;
    logic [4:0] bt;
    for (w = 0; w < 2; w++) begin
      for (c = 0; c < 4; c++) begin
        bt = (c == 0) ? 5'h1 : 5'h2 << c;
        @(posedge ref_clk);
        data_bus_32 <= w[0];
        acks = 0;
        wr(DMA_SETUP_OFS, {24'h00_0040, 4'h0, c[1:0], 1'b1, c[0]});
        #1;
        chk(dma_bursts_left, 64 / (w ? 4 : 2) / bt);
        n = 0;
        do begin
          settle();
          n++;
        end while (!dma_done && n < 300);
        chk(dma_done, 1'b1);
        chk(acks, 64 / (w ? 4 : 2) / bt);
        chk(dma_burst_beats, bt);
        chk(dma_to_ram, !c[0]);
        wr(DMA_SETUP_OFS, 32'h0);
      end
    end
    acks = 0;
    wr(DMA_SETUP_OFS, 32'h2);
    #1;
    chk(dma_done, 1'b1);
    chk(acks, 0);
    wr(DMA_SETUP_OFS, 32'h0);
  endtask
  task t_abort;
    wr(DMA_SETUP_OFS, 32'h0001_0002);
    repeat (5) @(posedge ref_clk);
    dones = 0;
    wr(DMA_SETUP_OFS, 32'h0);
    settle();
    chk(dma_active, 1'b0);
    repeat (20) @(posedge ref_clk);
    chk(dones, 0);
  endtask
  task t_walk;
    area_seen = 4'h0;
    bad = 0;
    wr(FILL_FLAGS_OFS, 32'h5);
    repeat (300) @(posedge ref_clk);
    chk(area_seen, 4'h5);
    chk(bad, 0);
    wr(FILL_FLAGS_OFS, 32'h0);
    repeat (8) @(posedge ref_clk);
    procs = 0;
    repeat (60) @(posedge ref_clk);
    chk(procs, 0);
  endtask
  initial begin
    ref_clk = 1'b0;
    rst_b = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 12'h0;
    reg_wdata = 32'h0;
    data_bus_32 = 1'b1;
    repeat (4) @(posedge ref_clk);
    rst_b <= 1'b1;
    t_regs();
    t_sreset();
    t_dma();
    t_abort();
    t_walk();
    tally_and_finish();
  end
endmodule
